// ==== verification/lro_checker.sv ====
// lro_checker.sv: port assertions for the receive output stage
// assumes it is bound to lro_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module lro_checker #(
    parameter logic [15:0] LOS_SET_CYC = 16'h1388,
    parameter logic [15:0] LOS_WIN_CYC = 16'h1388
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic wb_cyc_i,
    input  wire logic wb_stb_i,
    input  wire logic wb_ack_o,
    input  wire logic line_pos_pulse_i,
    input  wire logic line_neg_pulse_i,
    input  wire logic rx_clock_i,
    input  wire logic master_clock_present_i,
    input  wire logic host_control_i,
    input  wire logic rx_positive_data_o,
    input  wire logic rx_positive_data_oe_o,
    input  wire logic rx_negative_data_o,
    input  wire logic rx_negative_data_oe_o,
    input  wire logic signal_loss_flag_o
);
    logic [15:0] quiet_r;
    logic [5:0]  pin_age_r;
    logic [3:0]  rx_age_r;
    logic [2:0]  last_r;
    logic        edge_w;
    assign edge_w = (line_pos_pulse_i && !last_r[2])
                  || (line_neg_pulse_i && !last_r[1]);
    always_ff @(posedge clk_i) begin
        last_r <= {line_pos_pulse_i, line_neg_pulse_i, rx_clock_i};
        if (reset_i || edge_w)
            quiet_r <= 16'h0;
        else if (quiet_r != 16'hffff)
            quiet_r <= quiet_r + 16'h1;
        if (reset_i || host_control_i)
            pin_age_r <= 6'h0;
        else if (pin_age_r != 6'h3f)
            pin_age_r <= pin_age_r + 6'h1;
        if (reset_i || rx_clock_i != last_r[0])
            rx_age_r <= 4'h0;
        else if (rx_age_r != 4'hf)
            rx_age_r <= rx_age_r + 4'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_mclk_gone;
        !master_clock_present_i [*3];
    endsequence
    sequence s_mclk_up;
        master_clock_present_i [*4];
    endsequence
    property p_ack;
        s_req |=> wb_ack_o;
    endproperty
    property p_ack_one;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_float;
        s_mclk_gone |-> !rx_positive_data_oe_o && !rx_negative_data_oe_o;
    endproperty
    property p_oe_pair;
        s_mclk_up |-> rx_positive_data_oe_o && rx_negative_data_oe_o;
    endproperty
    property p_loss_set;
        quiet_r > LOS_SET_CYC + LOS_WIN_CYC + 16'h8 |-> signal_loss_flag_o;
    endproperty
    property p_loss_hold;
        signal_loss_flag_o && quiet_r > LOS_WIN_CYC + 16'h8
            |=> signal_loss_flag_o;
    endproperty
    property p_change;
        $changed(rx_positive_data_o) || $changed(rx_negative_data_o)
            |-> rx_age_r < 4'h8;
    endproperty
    property p_idle;
        quiet_r > 16'h40 && pin_age_r > 6'h1e
            |-> !rx_positive_data_o && !rx_negative_data_o;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    a_ack_one: assert property (p_ack_one) else $error("long ack");
    a_float: assert property (p_float) else $error("oe high");
    a_oe_pair: assert property (p_oe_pair) else $error("oe split");
    a_loss_set: assert property (p_loss_set) else $error("no loss");
    a_loss_hold: assert property (p_loss_hold) else $error("clr");
    a_change: assert property (p_change) else $error("off edge");
    a_idle: assert property (p_idle) else $error("not idle");
endmodule
bind lro_top lro_checker #(.LOS_SET_CYC(LOS_SET_CYC),
    .LOS_WIN_CYC(LOS_WIN_CYC)) u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .line_pos_pulse_i(line_pos_pulse_i),
    .line_neg_pulse_i(line_neg_pulse_i), .rx_clock_i(rx_clock_i),
    .master_clock_present_i(master_clock_present_i),
    .host_control_i(host_control_i),
    .rx_positive_data_o(rx_positive_data_o),
    .rx_positive_data_oe_o(rx_positive_data_oe_o),
    .rx_negative_data_o(rx_negative_data_o),
    .rx_negative_data_oe_o(rx_negative_data_oe_o),
    .signal_loss_flag_o(signal_loss_flag_o));
`default_nettype wire

// ==== verification/lro_framer_model.sv ====
// lro_framer_model.sv: downstream framer counting received ones
// assumes data is launched on the rx clock edge opposite the sample edge
`timescale 1ns/1ps
`default_nettype none
module lro_framer_model (
    input  wire logic        rx_clock_i,
    input  wire logic        sample_rise_i,
    input  wire logic        pos_i,
    input  wire logic        pos_oe_i,
    input  wire logic        neg_i,
    input  wire logic        neg_oe_i,
    output logic      [31:0] pos_ones_o,
    output logic      [31:0] neg_ones_o
);
    logic pos_r = 1'b0;
    logic neg_r = 1'b0;
    initial begin
        pos_ones_o = 32'h0;
        neg_ones_o = 32'h0;
    end
    always @(rx_clock_i) begin
        if (rx_clock_i === sample_rise_i) begin
            pos_r = pos_oe_i ? pos_i : ~pos_r;
            neg_r = neg_oe_i ? neg_i : ~neg_r;
            pos_ones_o = pos_ones_o + {31'h0, pos_r};
            neg_ones_o = neg_ones_o + {31'h0, neg_r};
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// tb.sv: register and line tests of the receive output stage
// assumes lro_top, the framer model and a 50 MHz clock
`include "lro_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0, reset_i = 1'b1, cyc = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, p0, n0, pc, nc, d;
    logic ack, irq, lpos = 1'b0, lneg = 1'b0, rclk = 1'b0, sel = 1'b1;
    logic mclk = 1'b1, host = 1'b0, po, poe, no, noe, los;
    logic [2:0] rdiv = 3'h0;
    int miscompares = 0, check_count = 0;
    lro_top #(.LOS_SET_CYC(16'h0040), .LOS_WIN_CYC(16'h0100)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
        .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .line_pos_pulse_i(lpos), .line_neg_pulse_i(lneg),
        .rx_clock_i(rclk), .clock_edge_select_i(sel),
        .master_clock_present_i(mclk), .host_control_i(host),
        .rx_positive_data_o(po), .rx_positive_data_oe_o(poe),
        .rx_negative_data_o(no), .rx_negative_data_oe_o(noe),
        .signal_loss_flag_o(los));
    lro_framer_model frm (.rx_clock_i(rclk), .sample_rise_i(sel),
        .pos_i(po), .pos_oe_i(poe), .neg_i(no), .neg_oe_i(noe),
        .pos_ones_o(pc), .neg_ones_o(nc));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        rdiv <= (rdiv == 3'h4) ? 3'h0 : rdiv + 3'h1;
        if (rdiv == 3'h4)
            rclk <= ~rclk;
    end
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] v);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= v;
        for (int i = 0; i < 17; i++) begin
            @(posedge clk_i);
            if (ack === 1'b1)
                break;
            if (i == 16) begin
                miscompares++;
                end_of_test();
            end
        end
        d = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rchk(input string nm, input logic [3:0] a,
                        input logic [31:0] e, m);
        wb(1'b0, a, 32'h0);
        chk(nm, d & m, e);
    endtask
    task automatic pulse(input logic p, input int n);
        repeat (n) begin
            @(posedge clk_i);
            lpos <= p;
            lneg <= ~p;
            repeat (3) @(posedge clk_i);
            lpos <= 1'b0;
            lneg <= 1'b0;
            repeat (6) @(posedge clk_i);
        end
    endtask
    task automatic wait_los(input logic e);
        for (int i = 0; i < 600 && los !== e; i++)
            @(posedge clk_i);
        chk("loss flag", {31'h0, los}, {31'h0, e});
        if (los !== e)
            end_of_test();
    endtask
    task automatic snap;
        repeat (20) @(posedge clk_i);
        p0 = pc;
        n0 = nc;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        rchk("gcr", `LRO_ADR_GCR, 32'h0, 32'h3);
        rchk("mask", `LRO_ADR_MASK, 32'h0, 32'h7);
        rchk("unmapped", 4'h2, 32'h0, 32'hffffffff);
        rchk("state", `LRO_ADR_STATE, 32'h4, 32'h6);
        $display("test reset done");
        wait_los(1'b1);
        rchk("status", `LRO_ADR_STATUS, 32'h1, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wb(1'b1, `LRO_ADR_MASK, 32'h7);
        chk("irq", {31'h0, irq}, 32'h1);
        wb(1'b1, `LRO_ADR_STATUS, 32'h7);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        repeat (300) @(posedge clk_i);
        chk("loss held", {31'h0, los}, 32'h1);
        $display("test loss set done");
        repeat (23) begin
            pulse(1'b1, 1);
            pulse(1'b0, 1);
        end
        wait_los(1'b0);
        rchk("status clr", `LRO_ADR_STATUS, 32'h2, 32'h6);
        wb(1'b1, `LRO_ADR_STATUS, 32'h7);
        $display("test loss clear done");
        for (int s = 0; s < 2; s++) begin
            sel <= s[0];
            snap();
            pulse(1'b1, 1);
            repeat (20) @(posedge clk_i);
            chk("pos bit", pc - p0, 32'h1);
            chk("pos quiet neg", nc - n0, 32'h0);
            snap();
            pulse(1'b0, 1);
            repeat (20) @(posedge clk_i);
            chk("neg bit", nc - n0, 32'h1);
            chk("neg quiet pos", pc - p0, 32'h0);
        end
        $display("test dual rail done");
        wb(1'b1, `LRO_ADR_GCR, 32'h2);
        p0 = pc;
        n0 = nc;
        pulse(1'b1, 2);
        repeat (20) @(posedge clk_i);
        chk("single data", pc - p0, 32'h2);
        chk("violation flag", nc - n0, 32'h1);
        rchk("violation", `LRO_ADR_STATUS, 32'h4, 32'h4);
        $display("test single rail done");
        wb(1'b1, `LRO_ADR_GCR, 32'h1);
        host <= 1'b1;
        wait_los(1'b1);
        rchk("ais on", `LRO_ADR_STATE, 32'h8, 32'h8);
        snap();
        repeat (40) @(posedge clk_i);
        chk("ais pos", pc - p0, 32'h2);
        chk("ais neg", nc - n0, 32'h2);
        wb(1'b1, `LRO_ADR_GCR, 32'h0);
        rchk("ais off", `LRO_ADR_STATE, 32'h0, 32'h8);
        host <= 1'b0;
        wb(1'b1, `LRO_ADR_GCR, 32'h1);
        rchk("pin mode", `LRO_ADR_STATE, 32'h0, 32'h8);
        snap();
        pulse(1'b1, 1);
        repeat (20) @(posedge clk_i);
        chk("pin mode data", pc - p0, 32'h1);
        chk("pin mode neg", nc - n0, 32'h0);
        $display("test alarm done");
        mclk <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("float", {30'h0, poe, noe}, 32'h0);
        mclk <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("drive", {30'h0, poe, noe}, 32'h3);
        $display("test float done");
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== verilog/lro_consts.svh ====
// lro_consts.svh: offsets, field positions, reset values and timing counts
// assumes a 50 MHz system clock and a 32-bit classic wishbone slave
`ifndef LRO_CONSTS_SVH
`define LRO_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define LRO_ADR_GCR    4'h0
`define LRO_ADR_STATUS 4'h4
`define LRO_ADR_MASK   4'h8
`define LRO_ADR_STATE  4'hc

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define LRO_GCR_AIS_BIT   0
`define LRO_GCR_SRAIL_BIT 1
`define LRO_GCR_RST       2'h0
`define LRO_EVT_RST       3'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define LRO_CLK_NS         20
`define LRO_LOS_SET_NS     100000
`define LRO_LOS_WIN_NS     100000
`define LRO_LOS_CLR_PULSES 16'h0010
`define LRO_LOS_SET_CYC \
    ((`LRO_LOS_SET_NS + `LRO_CLK_NS - 1) / `LRO_CLK_NS)
`define LRO_LOS_WIN_CYC (`LRO_LOS_WIN_NS / `LRO_CLK_NS)

`endif

// ==== verilog/lro_los_det.sv ====
// lro_los_det.sv: loss of signal detector on line pulse events
// assumes pulse_i is a one-cycle event per received line pulse
`timescale 1ns/1ps
`default_nettype none
module lro_los_det #(
    parameter logic [15:0] SET_CYC    = 16'h1388,
    parameter logic [15:0] WIN_CYC    = 16'h1388,
    parameter logic [15:0] CLR_PULSES = 16'h0010
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic pulse_i,
    output logic      los_o
);
    logic        los_r;
    logic [15:0] quiet_r;
    logic [15:0] win_r;
    logic [15:0] cnt_r;
    wire         quiet_end = (quiet_r == SET_CYC - 16'h0001);
    wire         win_end   = (win_r == WIN_CYC - 16'h0001);
    wire  [15:0] cnt_inc   = cnt_r + {15'h0000, pulse_i};
    wire         enough    = (cnt_inc >= CLR_PULSES);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            los_r   <= 1'b0;
            quiet_r <= 16'h0000;
            win_r   <= 16'h0000;
            cnt_r   <= 16'h0000;
        end else if (!los_r) begin
            win_r   <= 16'h0000;
            cnt_r   <= 16'h0000;
            quiet_r <= pulse_i ? 16'h0000 : quiet_r + 16'h0001;
            los_r   <= !pulse_i && quiet_end;
        end else begin
            quiet_r <= 16'h0000;
            win_r   <= win_end ? 16'h0000 : win_r + 16'h0001;
            cnt_r   <= win_end ? 16'h0000 : cnt_inc;
            los_r   <= !(win_end && enough);
        end
    end

    assign los_o = los_r;
endmodule
`default_nettype wire

// ==== verilog/lro_pkg.sv ====
// lro_pkg.sv: types shared by the receive output stage
// assumes lro_consts.svh for the numbers
`default_nettype none
package lro_pkg;

    // ------------------------------------------------------------------
    // control and event carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic single_rail;
        logic alarm_insert_enable;
    } lro_gcr_t;

    typedef struct packed {
        logic violation;
        logic loss_clear;
        logic loss_set;
    } lro_evt_t;

    typedef struct packed {
        logic pos;
        logic neg;
    } lro_rail_t;

endpackage
`default_nettype wire

// ==== verilog/lro_sync.sv ====
// lro_sync.sv: two flip-flop synchroniser for pin levels
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module lro_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= d_i;
            q_r    <= meta_r;
        end
    end

    assign q_o = q_r;
endmodule
`default_nettype wire

// ==== verilog/lro_top.sv ====
// lro_top.sv: receive output stage of one line channel
// assumes line pulse pins, recovered clock and straps are asynchronous
// to clk_i, and software on a classic 32-bit wishbone bus
`include "lro_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module lro_top
    import lro_pkg::*;
#(
    parameter logic [15:0] LOS_SET_CYC = 16'(`LRO_LOS_SET_CYC),
    parameter logic [15:0] LOS_WIN_CYC = 16'(`LRO_LOS_WIN_CYC)
) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    // line side pins
    input  wire logic        line_pos_pulse_i,
    input  wire logic        line_neg_pulse_i,
    input  wire logic        rx_clock_i,
    input  wire logic        clock_edge_select_i,
    input  wire logic        master_clock_present_i,
    input  wire logic        host_control_i,
    // framer side pins
    output logic             rx_positive_data_o,
    output logic             rx_positive_data_oe_o,
    output logic             rx_negative_data_o,
    output logic             rx_negative_data_oe_o,
    output logic             signal_loss_flag_o
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [5:0] pins_s;

    lro_sync #(
        .WIDTH (6)
    ) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .d_i     ({line_pos_pulse_i, line_neg_pulse_i, rx_clock_i,
                   clock_edge_select_i, master_clock_present_i,
                   host_control_i}),
        .q_o     (pins_s)
    );

    wire pos_s  = pins_s[5];
    wire neg_s  = pins_s[4];
    wire rclk_s = pins_s[3];
    wire cse_s  = pins_s[2];
    wire mclk_s = pins_s[1];
    wire host_s = pins_s[0];

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    logic pos_d_r;
    logic neg_d_r;
    logic rclk_d_r;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pos_d_r <= 1'b0;
        end else begin
            pos_d_r <= pos_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            neg_d_r <= 1'b0;
        end else begin
            neg_d_r <= neg_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rclk_d_r <= 1'b0;
        end else begin
            rclk_d_r <= rclk_s;
        end
    end

    lro_rail_t pulse;

    assign pulse.pos = pos_s && !pos_d_r;
    assign pulse.neg = neg_s && !neg_d_r;

    wire rclk_rise = rclk_s && !rclk_d_r;
    wire rclk_fall = !rclk_s && rclk_d_r;
    wire any_pulse = pulse.pos || pulse.neg;

    // outputs change on the opposite edge of the one the framer samples
    wire update = cse_s ? rclk_fall : rclk_rise;

    // ------------------------------------------------------------------
    // loss of signal
    // ------------------------------------------------------------------
    logic los;
    logic los_d_r;

    lro_los_det #(
        .SET_CYC    (LOS_SET_CYC),
        .WIN_CYC    (LOS_WIN_CYC),
        .CLR_PULSES (`LRO_LOS_CLR_PULSES)
    ) u_los (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pulse_i (any_pulse),
        .los_o   (los)
    );

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            los_d_r <= 1'b0;
        end else begin
            los_d_r <= los;
        end
    end

    // ------------------------------------------------------------------
    // control register and alarm selection
    // ------------------------------------------------------------------
    lro_gcr_t gcr_r;
    lro_gcr_t gcr_nxt;

    wire host_mode  = host_s;
    // pin control never inserts the alarm; host control obeys the bit
    wire ais_active = host_mode && gcr_r.alarm_insert_enable
                      && los;
    wire srail      = gcr_r.single_rail;

    // ------------------------------------------------------------------
    // code violation detection
    // ------------------------------------------------------------------
    logic last_neg_r;
    logic seen_r;

    // two pulses of the same polarity in a row break alternate marks
    wire in_service = !los && !ais_active;
    wire same_pol   = seen_r && ((pulse.pos && !last_neg_r)
                      || (pulse.neg && last_neg_r));
    wire viol_evt   = in_service && any_pulse && same_pol;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            last_neg_r <= 1'b0;
            seen_r     <= 1'b0;
        end else if (los) begin
            seen_r     <= 1'b0;
        end else if (any_pulse) begin
            last_neg_r <= pulse.neg;
            seen_r     <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // pending line data held until the next output edge
    // ------------------------------------------------------------------
    logic pend_pos_r;
    logic pend_neg_r;
    logic pend_viol_r;
    logic ais_phase_r;

    // a pulse in the update cycle itself is kept, not dropped
    wire pend_pos_nxt  = (pend_pos_r && !update) || pulse.pos;
    wire pend_neg_nxt  = (pend_neg_r && !update) || pulse.neg;
    wire pend_viol_nxt = (pend_viol_r && !update) || viol_evt;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_pos_r <= 1'b0;
        end else begin
            pend_pos_r <= pend_pos_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_neg_r <= 1'b0;
        end else begin
            pend_neg_r <= pend_neg_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_viol_r <= 1'b0;
        end else begin
            pend_viol_r <= pend_viol_nxt;
        end
    end

    // all ones: every bit a mark, marks alternate polarity on dual rail
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ais_phase_r <= 1'b0;
        end else if (update && ais_active) begin
            ais_phase_r <= !ais_phase_r;
        end
    end

    // ------------------------------------------------------------------
    // output data selection
    // ------------------------------------------------------------------
    lro_rail_t line_dual;
    lro_rail_t line_single;
    lro_rail_t ais_out;
    lro_rail_t out_nxt;
    lro_rail_t out_r;

    assign line_dual.pos   = pend_pos_r;
    assign line_dual.neg   = pend_neg_r;
    assign line_single.pos = pend_pos_r || pend_neg_r;
    assign line_single.neg = pend_viol_r;
    assign ais_out.pos     = srail ? 1'b1 : !ais_phase_r;
    assign ais_out.neg     = srail ? 1'b0 : ais_phase_r;

    assign out_nxt = ais_active ? ais_out
                   : (srail ? line_single : line_dual);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            out_r <= '0;
        end else if (update) begin
            out_r <= out_nxt;
        end
    end

    assign rx_positive_data_o    = out_r.pos;
    assign rx_negative_data_o    = out_r.neg;
    assign rx_positive_data_oe_o = mclk_s;
    assign rx_negative_data_oe_o = mclk_s;
    assign signal_loss_flag_o    = los_d_r;

    // ------------------------------------------------------------------
    // events, status and mask
    // ------------------------------------------------------------------
    lro_evt_t evt;
    lro_evt_t status_r;
    lro_evt_t status_nxt;
    lro_evt_t mask_r;
    lro_evt_t mask_nxt;
    lro_evt_t w1c;

    assign evt.loss_set   = los && !los_d_r;
    assign evt.loss_clear = !los && los_d_r;
    assign evt.violation  = viol_evt;

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    logic        ack_r;
    logic [31:0] dat_r;

    wire req      = wb_cyc_i && wb_stb_i;
    wire wr_take  = req && ack_r && wb_we_i && wb_sel_i[0];
    wire hit_gcr  = (wb_adr_i == `LRO_ADR_GCR);
    wire hit_stat = (wb_adr_i == `LRO_ADR_STATUS);
    wire hit_mask = (wb_adr_i == `LRO_ADR_MASK);
    wire hit_st   = (wb_adr_i == `LRO_ADR_STATE);

    wire [31:0] rd_gcr  = {30'h00000000, gcr_r};
    wire [31:0] rd_stat = {29'h00000000, status_r};
    wire [31:0] rd_mask = {29'h00000000, mask_r};
    wire [31:0] rd_st   = {28'h0000000, ais_active, mclk_s,
                           host_mode, los_d_r};

    wire [31:0] rd_mux = hit_gcr  ? rd_gcr
                       : hit_stat ? rd_stat
                       : hit_mask ? rd_mask
                       : hit_st   ? rd_st
                       : 32'h00000000;

    // writes take effect at the edge where the master sees ack
    assign gcr_nxt = (wr_take && hit_gcr)
                   ? lro_gcr_t'(wb_dat_i[1:0]) : gcr_r;
    assign mask_nxt = (wr_take && hit_mask)
                    ? lro_evt_t'(wb_dat_i[2:0]) : mask_r;
    assign w1c = (wr_take && hit_stat)
               ? lro_evt_t'(wb_dat_i[2:0]) : lro_evt_t'(3'h0);

    // a new event in the clearing cycle stays set
    assign status_nxt = (status_r & ~w1c) | evt;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dat_r <= 32'h00000000;
        end else begin
            dat_r <= rd_mux;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            gcr_r <= lro_gcr_t'(`LRO_GCR_RST);
        end else begin
            gcr_r <= gcr_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mask_r <= lro_evt_t'(`LRO_EVT_RST);
        end else begin
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            status_r <= lro_evt_t'(`LRO_EVT_RST);
        end else begin
            status_r <= status_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irq_o    = |(status_r & mask_r);

endmodule
`default_nettype wire
